// ### hw/mfio_consts.svh
// constants of the multifunction terminal logic
`ifndef MFIO_CONSTS_SVH
`define MFIO_CONSTS_SVH

// clock and timer base
`define MFIO_CLK_PERIOD_NS  25
`define MFIO_TICK_NS        100000000
`define MFIO_TICK_CYCLES    (`MFIO_TICK_NS / `MFIO_CLK_PERIOD_NS)

// register byte offsets
`define MFIO_OFS_INSEL_A    5'h00
`define MFIO_OFS_INSEL_B    5'h04
`define MFIO_OFS_OUTSEL     5'h08
`define MFIO_OFS_ON_DLY     5'h0c
`define MFIO_OFS_OFF_DLY    5'h10
`define MFIO_OFS_ZERO_LVL   5'h14
`define MFIO_OFS_CLOSE_DLY  5'h18
`define MFIO_OFS_STATUS     5'h1c

// reset values
`define MFIO_RST_INSEL1     8'h80
`define MFIO_RST_INSEL2     8'h84
`define MFIO_RST_INSEL3     8'h81
`define MFIO_RST_INSEL4     8'h83
`define MFIO_RST_INSEL5     8'h0f
`define MFIO_RST_OUTSEL1    8'h00
`define MFIO_RST_OUTSEL2    8'h01
`define MFIO_RST_OUTSEL3    8'h02
`define MFIO_RST_ON_DLY     16'h0000
`define MFIO_RST_OFF_DLY    16'h0000
`define MFIO_RST_ZERO_LVL   16'h0000
`define MFIO_RST_CLOSE_DLY  16'h000a

// input function codes
`define MFIO_IN_TIMER       8'h18
`define MFIO_IN_FEEDBACK    8'h86

// output function codes
`define MFIO_OUT_RUN        8'h00
`define MFIO_OUT_ZERO_SPD   8'h01
`define MFIO_OUT_READY      8'h06
`define MFIO_OUT_UNDERVOLT  8'h07
`define MFIO_OUT_BB         8'h08
`define MFIO_OUT_REF_SRC    8'h09
`define MFIO_OUT_RUN_SRC    8'h0a
`define MFIO_OUT_FAULT      8'h0e
`define MFIO_OUT_MINOR      8'h10
`define MFIO_OUT_RESET      8'h11
`define MFIO_OUT_TIMER      8'h12
`define MFIO_OUT_REVERSE    8'h1a
`define MFIO_OUT_BB2        8'h1b
`define MFIO_OUT_REGEN      8'h1d
`define MFIO_OUT_RUN2       8'h37

// status register fields
`define MFIO_ST_FAULT       0
`define MFIO_ST_CASE1       1
`define MFIO_ST_CASE2       2
`define MFIO_ST_CASE3       3
`define MFIO_ST_TIMER       4
`define MFIO_ST_RELAY       5
`define MFIO_ST_INPUTS      8
`define MFIO_ST_HWBB        13

`endif

// ### hw/mfio_pkg.sv
// types of the multifunction terminal logic
package mfio_pkg;

	// contactor supervision states, one-hot
	typedef enum logic [2:0] {
		CST_IDLE    = 3'b001,
		CST_CLOSING = 3'b010,
		CST_CLOSED  = 3'b100
	} mfio_cst_t;

	typedef logic [7:0] mfio_sel_t;

endpackage

// ### hw/mfio_sync.sv
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module mfio_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         mclk_i,
	input  wire logic         reset_i,
	// pins and filtered levels
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] level_o
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	// shift chain, first stage read only by the second
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= pin_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// level follows once stages two and three agree
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			level_o <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_r[i] == s3_r[i]) begin
					level_o[i] <= s3_r[i];
				end
			end
		end
	end

endmodule
`default_nettype wire

// ### hw/mfio_top.sv
// multifunction input/output terminal logic of a lift drive
// Operation
// - code 18 input, code 12 timer output
// - timer output on after on-delay
// - timer output off after off-delay
// - code 86 input is contactor feedback
// - fault: feedback closed before close command
// - fault: feedback late beyond close delay
// - fault: contactor opens while running
// - output selections reset to 0,1,2
// - code 0: run command or voltage
// - code 37: frequency being output
// - code 1: frequency below zero level
// - code 6: ready after clean initialisation
// - code 7: during DC bus undervoltage
// - code 8: during output baseblock
// - code 9: panel is frequency source
// - code A: panel is run source
// - code E: major fault except comm
// - code 10: minor fault present
// - code 11: fault reset command applied
// - code 1A: reverse run command active
// - code 1B: off during hardware baseblock
// - code 1D: regenerative operation
// - open baseblock input means baseblock
`timescale 1ns/1ps
`default_nettype none
`include "mfio_consts.svh"

module mfio_top
	import mfio_pkg::*;
#(
	parameter int TICK_CYCLES = `MFIO_TICK_CYCLES
) (
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	// avalon-mm slave
	input  wire logic [4:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	// terminal pins
	input  wire logic [4:0]  term_in_i,
	input  wire logic        hw_baseblock_input_i,
	// drive status, same clock
	input  wire logic        run_cmd_i,
	input  wire logic        volt_out_i,
	input  wire logic        freq_out_i,
	input  wire logic [15:0] out_freq_i,
	input  wire logic        init_done_i,
	input  wire logic        undervolt_i,
	input  wire logic        baseblocked_i,
	input  wire logic        ref_src_panel_i,
	input  wire logic        run_src_panel_i,
	input  wire logic        major_fault_i,
	input  wire logic        control_comm_fault_a_i,
	input  wire logic        control_comm_fault_b_i,
	input  wire logic        minor_fault_i,
	input  wire logic        fault_reset_i,
	input  wire logic        reverse_cmd_i,
	input  wire logic        regen_i,
	input  wire logic        contactor_close_cmd_i,
	input  wire logic        drive_running_i,
	// relay outputs and fault
	output logic             relay_output_1_o,
	output logic             relay_output_2_o,
	output logic             relay_output_3_o,
	output logic             contactor_feedback_fault_o
);

	localparam int PW = $clog2(TICK_CYCLES + 1);
	localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////
	// registers and state

	mfio_sel_t   in_sel_r [5];
	mfio_sel_t   out_sel_r [3];
	logic [15:0] on_dly_r;
	logic [15:0] off_dly_r;
	logic [15:0] zero_lvl_r;
	logic [15:0] close_dly_r;
	logic        wait_r;
	logic [4:0]  in_lvl;
	logic        s8_lvl;
	logic        hw_bb_act;
	logic        tmr_in;
	logic        fb_in;
	logic        fb_used;
	logic        tmr_out_r;
	logic [PW-1:0] tmr_pre_r;
	logic [15:0] tmr_tick_r;
	logic [PW-1:0] cst_pre_r;
	logic [15:0] cst_tick_r;
	mfio_cst_t   cst_r;
	logic        case1;
	logic        case2;
	logic        case3;
	logic [3:0]  flt_r;
	logic [2:0]  rel_r;
	logic        req;
	logic        wr_ok;
	logic        clr_flt;
	logic [31:0] wr_word;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// byte-lane merge of a write
	function automatic logic [31:0] merge(input logic [31:0] old,
	                                      input logic [31:0] wd,
	                                      input logic [3:0]  be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r;
	endfunction

	// current contents of a register word, unmapped reads as zero
	function automatic logic [31:0] reg_word(input logic [4:0] a);
		logic [31:0] w;
		w = 32'h00000000;
		case (a)
			`MFIO_OFS_INSEL_A:   w = {in_sel_r[3], in_sel_r[2], in_sel_r[1],
			                          in_sel_r[0]};
			`MFIO_OFS_INSEL_B:   w = {24'h000000, in_sel_r[4]};
			`MFIO_OFS_OUTSEL:    w = {8'h00, out_sel_r[2], out_sel_r[1],
			                          out_sel_r[0]};
			`MFIO_OFS_ON_DLY:    w = {16'h0000, on_dly_r};
			`MFIO_OFS_OFF_DLY:   w = {16'h0000, off_dly_r};
			`MFIO_OFS_ZERO_LVL:  w = {16'h0000, zero_lvl_r};
			`MFIO_OFS_CLOSE_DLY: w = {16'h0000, close_dly_r};
			`MFIO_OFS_STATUS:    w = {18'h00000, hw_bb_act, in_lvl, rel_r,
			                          tmr_out_r, flt_r};
			default:             w = 32'h00000000;
		endcase
		return w;
	endfunction

	// output function selected by a code
	function automatic logic out_fn(input mfio_sel_t code);
		logic v;
		v = 1'b0;
		case (code)
			`MFIO_OUT_RUN:       v = run_cmd_i | volt_out_i;
			`MFIO_OUT_RUN2:      v = freq_out_i;
			`MFIO_OUT_ZERO_SPD:  v = out_freq_i < zero_lvl_r;
			`MFIO_OUT_READY:     v = init_done_i & ~major_fault_i;
			`MFIO_OUT_UNDERVOLT: v = undervolt_i;
			`MFIO_OUT_BB:        v = baseblocked_i | hw_bb_act;
			`MFIO_OUT_REF_SRC:   v = ref_src_panel_i;
			`MFIO_OUT_RUN_SRC:   v = run_src_panel_i;
			`MFIO_OUT_FAULT:     v = major_fault_i & ~control_comm_fault_a_i
			                         & ~control_comm_fault_b_i;
			`MFIO_OUT_MINOR:     v = minor_fault_i;
			`MFIO_OUT_RESET:     v = fault_reset_i;
			`MFIO_OUT_TIMER:     v = tmr_out_r;
			`MFIO_OUT_REVERSE:   v = reverse_cmd_i;
			`MFIO_OUT_BB2:       v = ~hw_bb_act;
			`MFIO_OUT_REGEN:     v = regen_i;
			default:             v = 1'b0;
		endcase
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	mfio_sync #(.W(6)) u_sync (
		.mclk_i  (mclk_i),
		.reset_i (reset_i),
		.pin_i   ({hw_baseblock_input_i, term_in_i}),
		.level_o ({s8_lvl, in_lvl})
	);

	assign hw_bb_act = ~s8_lvl;

	// input function routing
	always_comb begin
		tmr_in  = 1'b0;
		fb_in   = 1'b0;
		fb_used = 1'b0;
		for (int i = 0; i < 5; i++) begin
			tmr_in = tmr_in | (in_lvl[i] & (in_sel_r[i] == `MFIO_IN_TIMER));
			fb_in   = fb_in | (in_lvl[i] & (in_sel_r[i] == `MFIO_IN_FEEDBACK));
			fb_used = fb_used | (in_sel_r[i] == `MFIO_IN_FEEDBACK);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// avalon slave, one wait cycle per access

	assign req     = avs_read_i | avs_write_i;
	assign wr_ok   = avs_write_i & ~wait_r;
	assign clr_flt = wr_ok & (avs_address_i == `MFIO_OFS_STATUS)
	                 & avs_byteenable_i[0]
	                 & avs_writedata_i[`MFIO_ST_FAULT];

	// addressed word with the written byte lanes merged in
	always_comb begin
		wr_word = merge(reg_word(avs_address_i), avs_writedata_i,
		                avs_byteenable_i);
	end

	// waitrequest drops for one cycle after a request
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			wait_r <= 1'b1;
		end else begin
			wait_r <= ~(req & wait_r);
		end
	end
	assign avs_waitrequest_o = wait_r;

	// configuration writes
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			in_sel_r[0] <= `MFIO_RST_INSEL1;
			in_sel_r[1] <= `MFIO_RST_INSEL2;
			in_sel_r[2] <= `MFIO_RST_INSEL3;
			in_sel_r[3] <= `MFIO_RST_INSEL4;
			in_sel_r[4] <= `MFIO_RST_INSEL5;
			out_sel_r[0] <= `MFIO_RST_OUTSEL1;
			out_sel_r[1] <= `MFIO_RST_OUTSEL2;
			out_sel_r[2] <= `MFIO_RST_OUTSEL3;
			on_dly_r    <= `MFIO_RST_ON_DLY;
			off_dly_r   <= `MFIO_RST_OFF_DLY;
			zero_lvl_r  <= `MFIO_RST_ZERO_LVL;
			close_dly_r <= `MFIO_RST_CLOSE_DLY;
		end else if (wr_ok) begin
			case (avs_address_i)
				`MFIO_OFS_INSEL_A: begin
					in_sel_r[0] <= wr_word[7:0];
					in_sel_r[1] <= wr_word[15:8];
					in_sel_r[2] <= wr_word[23:16];
					in_sel_r[3] <= wr_word[31:24];
				end
				`MFIO_OFS_INSEL_B:   in_sel_r[4] <= wr_word[7:0];
				`MFIO_OFS_OUTSEL: begin
					out_sel_r[0] <= wr_word[7:0];
					out_sel_r[1] <= wr_word[15:8];
					out_sel_r[2] <= wr_word[23:16];
				end
				`MFIO_OFS_ON_DLY:    on_dly_r    <= wr_word[15:0];
				`MFIO_OFS_OFF_DLY:   off_dly_r   <= wr_word[15:0];
				`MFIO_OFS_ZERO_LVL:  zero_lvl_r  <= wr_word[15:0];
				`MFIO_OFS_CLOSE_DLY: close_dly_r <= wr_word[15:0];
				default: begin
				end
			endcase
		end
	end

	// read data, unmapped reads as zero
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			avs_readdata_o <= 32'h00000000;
		end else begin
			avs_readdata_o <= reg_word(avs_address_i);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// input-to-output timer, delays in 0.1 s steps

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			tmr_out_r  <= 1'b0;
			tmr_pre_r  <= '0;
			tmr_tick_r <= 16'h0000;
		end else if (tmr_in == tmr_out_r) begin
			tmr_pre_r  <= '0;
			tmr_tick_r <= 16'h0000;
		end else if (tmr_tick_r >= (tmr_in ? on_dly_r : off_dly_r)) begin
			tmr_out_r  <= tmr_in;
			tmr_pre_r  <= '0;
			tmr_tick_r <= 16'h0000;
		end else if (tmr_pre_r == PRE_LAST) begin
			tmr_pre_r  <= '0;
			tmr_tick_r <= tmr_tick_r + 16'h0001;
		end else begin
			tmr_pre_r  <= tmr_pre_r + PW'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// contactor answer-back supervision

	assign case1 = fb_used & (cst_r == CST_IDLE) & fb_in
	               & ~contactor_close_cmd_i;
	assign case2 = fb_used & (cst_r == CST_CLOSING) & ~fb_in
	               & (cst_tick_r >= close_dly_r);
	assign case3 = fb_used & (cst_r == CST_CLOSED) & ~fb_in
	               & drive_running_i;

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			cst_r <= CST_IDLE;
		end else begin
			case (cst_r)
				CST_IDLE: begin
					if (contactor_close_cmd_i) cst_r <= CST_CLOSING;
				end
				CST_CLOSING: begin
					if (!contactor_close_cmd_i) cst_r <= CST_IDLE;
					else if (fb_in)             cst_r <= CST_CLOSED;
				end
				CST_CLOSED: begin
					if (!contactor_close_cmd_i) cst_r <= CST_IDLE;
				end
				default: cst_r <= CST_IDLE;
			endcase
		end
	end

	// close delay counter, runs only while closing
	always_ff @(posedge mclk_i) begin
		if (reset_i || cst_r != CST_CLOSING) begin
			cst_pre_r  <= '0;
			cst_tick_r <= 16'h0000;
		end else if (cst_pre_r == PRE_LAST) begin
			cst_pre_r  <= '0;
			if (cst_tick_r != 16'hffff) cst_tick_r <= cst_tick_r + 16'h0001;
		end else begin
			cst_pre_r  <= cst_pre_r + PW'(1);
		end
	end

	// sticky fault and cause, a new cause wins over a clear
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			flt_r <= 4'h0;
		end else begin
			if (clr_flt || fault_reset_i) flt_r <= 4'h0;
			if (case1 || case2 || case3) begin
				flt_r <= (clr_flt || fault_reset_i ? 4'h0 : flt_r)
				         | {case3, case2, case1, 1'b1};
			end
		end
	end
	assign contactor_feedback_fault_o = flt_r[`MFIO_ST_FAULT];

	////////////////////////////////////////////////////////////////////////
	// relay outputs

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			rel_r <= 3'b000;
		end else begin
			for (int k = 0; k < 3; k++) begin
				rel_r[k] <= out_fn(out_sel_r[k]);
			end
		end
	end
	assign relay_output_1_o = rel_r[0];
	assign relay_output_2_o = rel_r[1];
	assign relay_output_3_o = rel_r[2];

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	sequence s_sel1(logic [7:0] c);
		out_sel_r[0] == c;
	endsequence

	a_bus_wait_one: assert property (req && wait_r |=> !avs_waitrequest_o)
		else $error("waitrequest did not drop");
	a_timer_select: assert property ($rose(tmr_out_r) |-> $past(tmr_in))
		else $error("timer output rose without input");
	a_timer_on_wait: assert property (
		$rose(tmr_out_r) |-> $past(tmr_tick_r) >= $past(on_dly_r))
		else $error("timer output on too early");
	a_timer_off_wait: assert property (
		$fell(tmr_out_r) |-> $past(tmr_tick_r) >= $past(off_dly_r))
		else $error("timer output off too early");
	a_fb_needs_sel: assert property ($rose(flt_r[0]) |-> $past(fb_used))
		else $error("fault without feedback input");
	a_case1_flag: assert property (case1 |=> flt_r[1] && flt_r[0])
		else $error("early close not flagged");
	a_case2_flag: assert property (case2 |=> flt_r[2] && flt_r[0])
		else $error("close timeout not flagged");
	a_case3_flag: assert property (case3 |=> flt_r[3] && flt_r[0])
		else $error("opening in run not flagged");
	a_sel_reset: assert property ($fell(reset_i) |->
		out_sel_r[0] == 8'h00 && out_sel_r[1] == 8'h01
		&& out_sel_r[2] == 8'h02)
		else $error("output selections not at reset value");
	a_run_out: assert property (s_sel1(8'h00) ##0 (run_cmd_i || volt_out_i)
		|=> relay_output_1_o)
		else $error("run output missing");
	a_run2_out: assert property (s_sel1(8'h37) ##0 !freq_out_i
		|=> !relay_output_1_o)
		else $error("run 2 output on without frequency");
	a_zero_spd: assert property (s_sel1(8'h01) ##0 (out_freq_i > zero_lvl_r)
		|=> !relay_output_1_o)
		else $error("zero speed on above level");
	a_ready_out: assert property (s_sel1(8'h06) ##0 major_fault_i
		|=> !relay_output_1_o)
		else $error("ready shown with fault");
	a_uv_out: assert property (s_sel1(8'h07) ##0 undervolt_i
		|=> relay_output_1_o)
		else $error("undervoltage output missing");
	a_bb_out: assert property (s_sel1(8'h08) ##0 baseblocked_i
		|=> relay_output_1_o)
		else $error("baseblock output missing");
	a_ref_src: assert property (s_sel1(8'h09) ##0 !ref_src_panel_i
		|=> !relay_output_1_o)
		else $error("reference source output wrong");
	a_run_src: assert property (s_sel1(8'h0a) ##0 run_src_panel_i
		|=> relay_output_1_o)
		else $error("run source output missing");
	a_fault_out: assert property (s_sel1(8'h0e) ##0 control_comm_fault_a_i
		|=> !relay_output_1_o)
		else $error("fault output on comm fault");
	a_minor_out: assert property (s_sel1(8'h10) ##0 minor_fault_i
		|=> relay_output_1_o)
		else $error("minor fault output missing");
	a_reset_out: assert property (s_sel1(8'h11) ##0 fault_reset_i
		|=> relay_output_1_o)
		else $error("reset output missing");
	a_rev_out: assert property (s_sel1(8'h1a) ##0 !reverse_cmd_i
		|=> !relay_output_1_o)
		else $error("reverse output on for forward");
	a_bb2_out: assert property (s_sel1(8'h1b) ##0 hw_bb_act
		|=> !relay_output_1_o)
		else $error("baseblock 2 output on");
	a_regen_out: assert property (s_sel1(8'h1d) ##0 regen_i
		|=> relay_output_1_o)
		else $error("regen output missing");
	a_open_bb: assert property (!hw_baseblock_input_i [*6] |-> hw_bb_act)
		else $error("open input not baseblock");
	a_closed_bb: assert property (
		hw_baseblock_input_i [*6] |-> !hw_bb_act)
		else $error("closed input still baseblock");
	a_unknown_off: assert property (s_sel1(8'h02) |=> !relay_output_1_o)
		else $error("unknown code drives output");

endmodule
`default_nettype wire

// ### sim/mfio_contactor_model.sv
// behavioural model of the motor contactor and its auxiliary contact
`timescale 1ns/1ps
`default_nettype none

module mfio_contactor_model (
	// clock
	input  wire logic       mclk_i,
	// coil command and fault mode
	input  wire logic       close_i,
	input  wire logic [1:0] mode_i,
	// auxiliary contact
	output logic            fb_o
);
	logic [2:0] coil_r = 3'h0;

	// contact travel lag of three cycles
	always_ff @(posedge mclk_i) begin
		coil_r <= {coil_r[1:0], close_i};
	end

	// auxiliary contact answer
	// mode 1 welded open, mode 2 welded shut
	assign fb_o = (mode_i == 2'h1) ? 1'b0 :
	              (mode_i == 2'h2) ? 1'b1 : coil_r[2];
endmodule
`default_nettype wire

// ### sim/mfio_top_test.sv
// self-checking bench of the multifunction terminal logic
`timescale 1ns/1ps
`default_nettype none

module mfio_top_test;
	import mfio_pkg::*;
	logic        mclk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic [4:0]  adr = 5'h00;
	logic        rd = 1'b0, wr = 1'b0, bb = 1'b1, tin = 1'b0;
	logic [31:0] wdat = 32'h0, rdat;
	logic [15:0] freq = 16'h0;
	logic [16:0] st = 17'h0;
	logic [1:0]  mode = 2'h0;
	wire  [31:0] rdata;
	wire         wait_r, r1, r2, r3, flt, fb;
	int          errors = 0, samples_checked = 0;
	logic [7:0]  codes [12] = '{8'h00, 8'h00, 8'h37, 8'h06, 8'h07, 8'h08,
		8'h09, 8'h0a, 8'h0e, 8'h10, 8'h11, 8'h1a};
	int          bits [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 11, 12, 13};

	// clock of 25 ns
	always #12.5 mclk_i = ~mclk_i;

	mfio_top #(.TICK_CYCLES(4)) mfio_top_inst (
		.mclk_i(mclk_i), .reset_i(reset_i), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
		.avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wait_r), .term_in_i({3'h0, fb, tin}),
		.hw_baseblock_input_i(bb), .run_cmd_i(st[0]), .volt_out_i(st[1]),
		.freq_out_i(st[2]), .out_freq_i(freq), .init_done_i(st[3]),
		.undervolt_i(st[4]), .baseblocked_i(st[5]),
		.ref_src_panel_i(st[6]), .run_src_panel_i(st[7]),
		.major_fault_i(st[8]), .control_comm_fault_a_i(st[9]),
		.control_comm_fault_b_i(st[10]), .minor_fault_i(st[11]),
		.fault_reset_i(st[12]), .reverse_cmd_i(st[13]), .regen_i(st[14]),
		.contactor_close_cmd_i(st[15]), .drive_running_i(st[16]),
		.relay_output_1_o(r1), .relay_output_2_o(r2), .relay_output_3_o(r3),
		.contactor_feedback_fault_o(flt));

	mfio_contactor_model mfio_contactor_model_inst (.mclk_i(mclk_i),
		.close_i(st[15]), .mode_i(mode), .fb_o(fb));

	////////////////////////////////////////////////////////////////////
	// compare and report
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge mclk_i);
	endtask

	// avalon cycle, held until waitrequest seen low
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		adr <= a;
		wdat <= d;
		rd <= !w;
		wr <= w;
		@(posedge mclk_i);
		while (wait_r !== 1'b0 && n < 50) begin
			@(posedge mclk_i);
			n++;
		end
		if (n == 50)
			check(32'h0, 32'h1);
		rdat = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge mclk_i);
	endtask

	task automatic sel1(input logic [7:0] c);
		bus(1'b1, 5'h08, {8'h00, 8'h02, 8'h01, c});
	endtask

	////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		bus(1'b0, 5'h08, 32'h0);
		check(rdat, 32'h00020100);
		$display("reset test done");
	endtask

	task automatic t_status();
		for (int i = 0; i < 12; i++) begin
			sel1(codes[i]);
			st[bits[i]] <= 1'b1;
			cyc(3);
			check(r1, 1'b1);
			st <= 17'h0;
			cyc(3);
			check(r1, 1'b0);
		end
		sel1(8'h1d);
		st[14] <= 1'b1;
		cyc(3);
		check(r1, 1'b1);
		sel1(8'h0e);
		st <= 17'h00b00;
		cyc(3);
		check(r1, 1'b0);
		sel1(8'h02);
		st <= 17'h07fff;
		cyc(3);
		check(r1, 1'b0);
		check(r3, 1'b0);
		st <= 17'h0;
		$display("status test done");
	endtask

	task automatic t_pins();
		sel1(8'h1b);
		cyc(8);
		check(r1, 1'b1);
		bb <= 1'b0;
		cyc(8);
		check(r1, 1'b0);
		sel1(8'h08);
		cyc(3);
		check(r1, 1'b1);
		bb <= 1'b1;
		bus(1'b1, 5'h14, 32'd100);
		sel1(8'h01);
		freq <= 16'd50;
		cyc(3);
		check(r1, 1'b1);
		check(r2, 1'b1);
		freq <= 16'd100;
		cyc(3);
		check(r1, 1'b0);
		check(r2, 1'b0);
		$display("pin test done");
	endtask

	task automatic t_timer();
		bus(1'b1, 5'h00, 32'h83818418);
		bus(1'b1, 5'h0c, 32'h2);
		bus(1'b1, 5'h10, 32'h3);
		sel1(8'h12);
		tin <= 1'b1;
		cyc(6);
		check(r1, 1'b0);
		cyc(12);
		check(r1, 1'b1);
		tin <= 1'b0;
		cyc(10);
		check(r1, 1'b1);
		cyc(12);
		check(r1, 1'b0);
		$display("timer test done");
	endtask

	task automatic t_contact();
		bus(1'b1, 5'h00, 32'h83818680);
		mode <= 2'h2;
		cyc(12);
		check(flt, 1'b1);
		mode <= 2'h0;
		cyc(8);
		bus(1'b1, 5'h1c, 32'h1);
		check(flt, 1'b0);
		mode <= 2'h1;
		st[15] <= 1'b1;
		cyc(30);
		check(flt, 1'b0);
		cyc(20);
		check(flt, 1'b1);
		mode <= 2'h0;
		st[15] <= 1'b0;
		cyc(8);
		bus(1'b1, 5'h1c, 32'h1);
		st[15] <= 1'b1;
		cyc(10);
		st[16] <= 1'b1;
		cyc(5);
		check(flt, 1'b0);
		mode <= 2'h1;
		cyc(8);
		check(flt, 1'b1);
		$display("contactor test done");
	endtask

	////////////////////////////////////////////////////////////////////
	// main sequence and watchdog
	initial begin
		cyc(2);
		reset_i <= 1'b0;
		cyc(1);
		t_reset();
		t_status();
		t_pins();
		t_timer();
		t_contact();
		final_report();
	end

	initial begin
		#100us;
		errors++;
		final_report();
	end
endmodule
`default_nettype wire
